// [rtl/cies_core.sv]
`timescale 1ns/1ps
`default_nettype none
//Contract
// RULE_01 - NOP pattern changes nothing at all
// RULE_02 - Option-load copies W into option register
// RULE_03 - Option register also readable, writable as data
// RULE_04 - Software should prefer direct option writes
// RULE_05 - Interrupt return pops stack into PC
// RULE_06 - Interrupt return sets global_irq_enable bit 7
// RULE_07 - Interrupt return takes two cycles, second idle
// RULE_08 - Decode Q1, enable Q3, pop Q4
module cies_core
	import cies_pkg::*;
#(
	parameter int PC_W = 13
) (
	// Clock and reset
	input  wire logic            clk_sys,
	input  wire logic            nrst,
	// Fetch side
	input  wire logic [13:0]     instr,
	input  wire logic            instr_valid,
	// Core datapath
	input  wire logic [7:0]      w_reg,
	input  wire logic [PC_W-1:0] stack_top,
	// Direct data access to the option register
	input  wire logic            opt_wr,
	input  wire logic [7:0]      opt_wdata,
	// Direct data access to irq_control_reg
	input  wire logic            irqctl_wr,
	input  wire logic [7:0]      irqctl_wdata,
	// Results
	output logic [7:0]           option_reg,
	output logic [7:0]           irq_control_reg,
	output logic                 stack_pop,
	output logic                 pc_load,
	output logic [PC_W-1:0]      pc_value,
	output logic                 fetch_flush,
	output logic                 busy,
	output logic [3:0]           phase
);

	// Decoder result
	cies_cls_t       cls;

	// Sequencer state
	cies_phase_t     ph_r;
	cies_phase_t     ph_nxt;
	cies_cls_t       cur_r;
	cies_cls_t       cur_nxt;
	logic            second_r;
	logic            second_nxt;

	// Software visible registers
	logic [7:0]      opt_r;
	logic [7:0]      opt_nxt;
	logic [7:0]      ictl_r;
	logic [7:0]      ictl_nxt;

	// Return pulses and jump target
	logic            pop_r;
	logic            pop_nxt;
	logic            pcl_r;
	logic            pcl_nxt;
	logic [PC_W-1:0] pcv_r;
	logic [PC_W-1:0] pcv_nxt;
	logic            flush_r;
	logic            flush_nxt;

	// Word classifier
	cies_decode u_dec (
		.instr (instr),
		.cls   (cls)
	);

	// True when the held class runs in the given phase
	function automatic logic exec_at(
		input cies_cls_t   cls_now,
		input cies_phase_t ph_now,
		input cies_cls_t   cls_want,
		input cies_phase_t ph_want
	);
		exec_at = (cls_now == cls_want) && (ph_now == ph_want);
	endfunction : exec_at

	// Phase ring, word capture in Q1, idle second cycle
	always_comb begin
		// Hold unless a phase says otherwise
		ph_nxt     = ph_r;
		cur_nxt    = cur_r;
		second_nxt = second_r;
		case (ph_r)
			CIES_Q1: begin
				ph_nxt = CIES_Q2;
				// Second return cycle decodes nothing
				if (second_r) begin
					cur_nxt = CIES_CLS_NONE; // see RULE_07
				end else if (instr_valid) begin
					cur_nxt = cls; // see RULE_08
				end else begin
					cur_nxt = CIES_CLS_NONE;
				end
			end
			// Q2 only advances the ring
			CIES_Q2: begin
				ph_nxt = CIES_Q3;
			end
			// Q3 work sits in the register group
			CIES_Q3: begin
				ph_nxt = CIES_Q4;
			end
			// Q4 closes the instruction cycle
			CIES_Q4: begin
				ph_nxt = CIES_Q1;
				// Return arms the idle cycle, anything else ends it
				if (cur_r == CIES_CLS_RET) begin
					second_nxt = 1'b1; // see RULE_07
				end else begin
					second_nxt = 1'b0;
				end
			end
			// Corrupt phase code recovers to Q1
			default: begin
				ph_nxt = CIES_Q1;
			end
		endcase
	end

	// Sequencer registers, synchronous reset to Q1
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ph_r     <= CIES_Q1;
			cur_r    <= CIES_CLS_NONE;
			second_r <= 1'b0;
		end else begin
			ph_r     <= ph_nxt;
			cur_r    <= cur_nxt;
			second_r <= second_nxt;
		end
	end

	// Option and interrupt control registers
	always_comb begin
		// Hold by default
		opt_nxt  = opt_r;
		ictl_nxt = ictl_r;
		// Direct data writes, accepted in any phase
		if (opt_wr) begin
			opt_nxt = opt_wdata; // see RULE_03
		end
		if (irqctl_wr) begin
			ictl_nxt = irqctl_wdata;
		end

		// Option load in Q4 wins over a direct write
		if (exec_at(cur_r, ph_r, CIES_CLS_OPT, CIES_Q4)) begin
			opt_nxt = w_reg; // see RULE_02
		end
		// Enable set in Q3 wins over a direct bit 7 write
		if (exec_at(cur_r, ph_r, CIES_CLS_RET, CIES_Q3)) begin
			ictl_nxt[CIES_IRQ_EN_BIT] = 1'b1; // see RULE_06, RULE_08
		end

		// No-operation and unknown words leave both alone, see RULE_01
	end

	// Register flops, reset to idle values
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			opt_r  <= CIES_OPTION_RST;
			ictl_r <= CIES_IRQCTL_RST;
		end else begin
			opt_r  <= opt_nxt;
			ictl_r <= ictl_nxt;
		end
	end

	// Stack pop, program counter load and fetch flush
	always_comb begin
		// Pulses last one cycle
		pop_nxt   = 1'b0;
		pcl_nxt   = 1'b0;
		flush_nxt = 1'b0;
		// Target holds between returns
		pcv_nxt   = pcv_r;
		// Q4 of a return pops the stack and redirects fetch
		if (exec_at(cur_r, ph_r, CIES_CLS_RET, CIES_Q4)) begin
			pop_nxt   = 1'b1; // see RULE_05, RULE_08
			pcl_nxt   = 1'b1;
			flush_nxt = 1'b1;
		end

		// Popped top of stack becomes the new program counter
		if (exec_at(cur_r, ph_r, CIES_CLS_RET, CIES_Q4)) begin
			pcv_nxt = stack_top; // see RULE_05
		end
	end

	// Return pulse flops
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			pop_r   <= 1'b0;
			pcl_r   <= 1'b0;
			pcv_r   <= PC_W'(CIES_PC_RST);
			flush_r <= 1'b0;
		end else begin
			pop_r   <= pop_nxt;
			pcl_r   <= pcl_nxt;
			pcv_r   <= pcv_nxt;
			flush_r <= flush_nxt;
		end
	end

	// Outputs straight from flops
	assign option_reg      = opt_r;
	assign irq_control_reg = ictl_r;
	assign stack_pop       = pop_r;
	assign pc_load         = pcl_r;
	assign pc_value        = pcv_r;
	assign fetch_flush     = flush_r;
	assign busy            = second_r;
	assign phase           = ph_r;
endmodule : cies_core
`default_nettype wire

// [common/cies_pkg.sv]
package cies_pkg;
	// Instruction width and encodings
	localparam int          CIES_IW           = 14;
	localparam logic [13:0] CIES_NOP_VAL      = 14'h0000;
	localparam logic [13:0] CIES_NOP_MASK     = 14'h3f9f;
	localparam logic [13:0] CIES_OPT_LOAD_OP  = 14'h0062;
	localparam logic [13:0] CIES_RET_IRQ_OP   = 14'h0009;
	// Interrupt control layout
	localparam int          CIES_IRQ_EN_BIT   = 7;
	// Reset values
	localparam logic [7:0]  CIES_OPTION_RST   = 8'hff;
	localparam logic [7:0]  CIES_IRQCTL_RST   = 8'h00;
	localparam logic [12:0] CIES_PC_RST       = 13'h0000;
	// Cycle counts
	localparam int          CIES_RET_CYCLES   = 2;
	localparam int          CIES_PHASES       = 4;

	// Instruction class
	typedef enum logic [2:0] {
		CIES_CLS_NONE = 3'h0,
		CIES_CLS_NOP  = 3'h1,
		CIES_CLS_OPT  = 3'h2,
		CIES_CLS_RET  = 3'h3
	} cies_cls_t;

	// Phase within an instruction cycle
	typedef enum logic [3:0] {
		CIES_Q1 = 4'h1,
		CIES_Q2 = 4'h2,
		CIES_Q3 = 4'h4,
		CIES_Q4 = 4'h8
	} cies_phase_t;
endpackage : cies_pkg

// [rtl/cies_decode.sv]
`timescale 1ns/1ps
`default_nettype none
module cies_decode
	import cies_pkg::*;
(
	// Instruction word
	input  wire logic [13:0] instr,
	// Class
	output var  cies_cls_t   cls
);
	// Pattern match of the masked NOP pattern and the two exact words
	always_comb begin
		if ((instr & CIES_NOP_MASK) == CIES_NOP_VAL)
			cls = CIES_CLS_NOP; // see RULE_01
		else if (instr == CIES_OPT_LOAD_OP)
			cls = CIES_CLS_OPT; // see RULE_02
		else if (instr == CIES_RET_IRQ_OP)
			cls = CIES_CLS_RET; // see RULE_05
		else
			cls = CIES_CLS_NONE;
	end
endmodule : cies_decode
`default_nettype wire

// [dv/cies_stack_model.sv]
`timescale 1ns/1ps
`default_nettype none
module cies_stack_model (
	// Pop, refill, entry
	input wire logic        clk_sys,
	input wire logic        stack_pop,
	input wire logic        fill,
	input wire logic [12:0] push_val,
	output logic     [12:0] stack_top
);
	logic gone_r;
	// Popped entry is gone: show its inverse
	always_ff @(posedge clk_sys) gone_r <= fill ? 1'b0 : gone_r | stack_pop;
	assign stack_top = push_val ^ {13{gone_r}};
endmodule : cies_stack_model
`default_nettype wire

// [dv/cies_core_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module cies_chk #(
	parameter int PC_W = 13
) (
	// Clock and reset
	input wire logic            clk_sys,
	input wire logic            nrst,
	// Fetch side, datapath and direct writes
	input wire logic            instr_valid,
	input wire logic [13:0]     instr,
	input wire logic [7:0]      w_reg,
	input wire logic [PC_W-1:0] stack_top,
	input wire logic            opt_wr,
	input wire logic [7:0]      opt_wdata,
	input wire logic            irqctl_wr,
	// Results
	input wire logic [7:0]      option_reg,
	input wire logic [7:0]      irq_control_reg,
	input wire logic            stack_pop,
	input wire logic            pc_load,
	input wire logic [PC_W-1:0] pc_value,
	input wire logic            fetch_flush,
	input wire logic            busy,
	input wire logic [3:0]      phase
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	// Word taken this edge
	wire tk = phase == 4'h1 && instr_valid && !busy;
	wire rt = tk && instr == 14'h0009;
	ret_gie_a: assert property (rt |-> ##3 irq_control_reg[7]) else $error("enable");
	pop_once_a: assert property (stack_pop |=> !stack_pop) else $error("pop twice");
	ret_pop_a: assert property (rt |-> ##4 stack_pop && pc_load && fetch_flush) else $error("pop");
	pop_pc_a: assert property (stack_pop |-> pc_value == $past(stack_top)) else $error("pc");
	ret_idle_a: assert property (rt |-> ##4 busy [*4] ##1 !busy) else $error("idle");
	opt_load_a: assert property (tk && instr == 14'h0062 |-> ##4 option_reg == $past(w_reg)) else $error("opt");
	nop_quiet_a: assert property (tk && (instr & 14'h3f9f) == 0 && !opt_wr && !irqctl_wr
		##1 (!opt_wr && !irqctl_wr) [*3] |=> option_reg == $past(option_reg, 4)
		&& irq_control_reg == $past(irq_control_reg, 4)) else $error("nop");
	opt_wr_a: assert property (opt_wr && phase != 4'h8 |=> option_reg == $past(opt_wdata)) else $error("wr");
	cover property (rt);
	cover property (tk && instr == 14'h0062);
	cover property (tk && instr == 14'h0060);
endmodule : cies_chk
bind cies_core cies_chk #(.PC_W(PC_W)) u_chk (.clk_sys, .nrst, .instr_valid, .opt_wr, .irqctl_wr, .stack_pop, .pc_load,
	.fetch_flush, .busy, .instr, .stack_top, .pc_value, .w_reg, .opt_wdata, .option_reg, .irq_control_reg, .phase);
`default_nettype wire

// [dv/ctrl_instr_exec_subset_test.sv]
`timescale 1ns/1ps
`default_nettype none
module ctrl_instr_exec_subset_test;
	logic clk_sys = 0, nrst = 0, instr_valid = 0, opt_wr = 0, irqctl_wr = 0, fill = 1;
	logic [13:0] instr = 0;
	logic [12:0] push_val = 13'h1abc, stack_top, pc_value;
	logic [7:0] w_reg = 8'h4f, opt_wdata = 0, irqctl_wdata = 0, option_reg, irq_control_reg;
	logic stack_pop, pc_load, fetch_flush, busy;
	logic [3:0] phase;
	int failures = 0, checked = 0, cyc = 0;
	always #5 clk_sys = ~clk_sys;
	cies_core dut (.clk_sys, .nrst, .instr, .instr_valid, .w_reg, .stack_top, .opt_wr, .opt_wdata, .irqctl_wr,
		.irqctl_wdata, .option_reg, .irq_control_reg, .stack_pop, .pc_load, .pc_value, .fetch_flush, .busy, .phase);
	cies_stack_model stk (.clk_sys, .stack_pop, .fill, .push_val, .stack_top);
	task automatic chk(input logic [12:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %0t got %h want %h", $time, seen, exp);
		end
	endtask : chk
	// Offer one word in a free Q1 slot
	task automatic issue(input logic [13:0] w);
		@(negedge clk_sys);
		while (phase !== 4'h1 || busy !== 1'b0) @(negedge clk_sys);
		instr = w;
		instr_valid = 1;
		@(negedge clk_sys);
		instr_valid = 0;
	endtask : issue
	task automatic t_direct;
		chk(13'(option_reg), 13'hff);
		issue(14'h0000);
		opt_wr = 1;
		opt_wdata = 8'h5a;
		irqctl_wr = 1;
		irqctl_wdata = 8'h05;
		@(negedge clk_sys);
		opt_wr = 0;
		irqctl_wr = 0;
		chk(13'(option_reg), 13'h5a);
		chk(13'(irq_control_reg), 13'h05);
	endtask : t_direct
	task automatic t_opt;
		issue(14'h0062);
		repeat (3) @(negedge clk_sys);
		w_reg = 8'h11;
		issue(14'h0060);
		repeat (3) @(negedge clk_sys);
		chk(13'(option_reg), 13'h4f);
	endtask : t_opt
	task automatic t_ret;
		issue(14'h0009);
		repeat (3) @(negedge clk_sys);
		chk({stack_pop, busy}, 13'h3);
		chk({pc_load, fetch_flush}, 13'h3);
		chk(pc_value, 13'h1abc);
		chk(13'(irq_control_reg), 13'h85);
		// Word offered in the idle Q1 slot must be dropped
		w_reg = 8'h22;
		instr = 14'h0062;
		instr_valid = 1;
		@(negedge clk_sys);
		instr_valid = 0;
		chk({stack_pop, pc_load, fetch_flush}, 13'h0);
		repeat (3) @(negedge clk_sys);
		chk(13'(option_reg), 13'h4f);
		chk(13'(busy), 13'h0);
		w_reg = 8'h11;
		issue(14'h0062);
		repeat (3) @(negedge clk_sys);
		chk(13'(option_reg), 13'h11);
	endtask : t_ret
	task automatic conclude;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : conclude
	initial begin
		repeat (20) @(negedge clk_sys);
		nrst = 1;
		fill = 0;
		t_direct;
		t_opt;
		t_ret;
		conclude;
	end
	// Hang guard
	always @(posedge clk_sys) if (++cyc > 500) begin
		failures++;
		conclude;
	end
endmodule : ctrl_instr_exec_subset_test
`default_nettype wire
